//--- design/mme_pkg.sv
// constants shared by the monitor mode entry block
`default_nettype none
package mme_pkg;
  // monitor routine window and entry point
  localparam logic [15:0] MON_ROM_START = 16'hfe20;
  localparam logic [15:0] MON_ROM_END = 16'hff52;
  // reset vector locations and erased byte value
  localparam logic [15:0] VEC_ADDR_HI = 16'hfffe;
  localparam logic [15:0] VEC_ADDR_LO = 16'hffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // clocks and link rate
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int MON_BUS_HZ = 2_457_600;
  localparam int XTAL_PER_BUS = 4;
  localparam int MON_XTAL_HZ = MON_BUS_HZ * XTAL_PER_BUS;
  localparam int BUS_CLK_PER_BIT = MON_BUS_HZ / BAUD_HZ;
  // bit time in local clock cycles, half for mid-bit sampling
  localparam logic [11:0] BAUD_DIV = 12'(CLK_HZ / BAUD_HZ);
  localparam logic [11:0] BAUD_HALF = 12'(CLK_HZ / BAUD_HZ / 2);
  localparam logic [11:0] CNT_ZERO = 12'h000;
  // frame shape
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] TX_FRAME_BITS = 4'ha;
  // host write command: command, address high, address low, data
  localparam logic [7:0] CMD_WRITE = 8'h57;
  localparam logic [1:0] IDX_CMD = 2'h0;
  localparam logic [1:0] IDX_AHI = 2'h1;
  localparam logic [1:0] IDX_ALO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  // reset values
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_TX_SHIFT = 10'h3ff;
  // operating mode latch
  typedef enum logic [1:0] {
    MME_LATCH = 2'b00,
    MME_USER = 2'b01,
    MME_MON = 2'b10
  } mme_mode_t;
  // serial receiver
  typedef enum logic [1:0] {
    MME_RX_IDLE = 2'b00,
    MME_RX_START = 2'b01,
    MME_RX_DATA = 2'b10,
    MME_RX_STOP = 2'b11
  } mme_rx_t;
endpackage
`default_nettype wire

//--- design/mme_top.sv
// monitor mode entry: mode latch, protection gates and monitor serial link
// Function
// - monitor routine lives at FE20..FF52
// - blank flash programmed only in monitor
// - host writes device registers over link
// - elevated irq level at latch enters monitor
// - elevated entry keeps PLL off, divides clock; code only drives o_pll_enable low, no divider
// - blank reset vector also enters monitor
// - blank vector means whole array blank
// - blank entry, irq low enables PLL
// - protected erase needs elevated monitor entry
// - link runs 9600 baud from bus clock; code counts 2604 cycles of the 25 MHz local clock per bit
// - blank flash leaves ports at reset defaults
// - vector blank when both bytes read FF
// - mode latched once, held until reset
`default_nettype none
module mme_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // mode select levels
  input wire logic i_test_entry_voltage,
  input wire logic i_irq_pin_level,
  input wire logic [7:0] i_vec_hi_byte,
  input wire logic [7:0] i_vec_lo_byte,
  // cpu and flash requests
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_prog_req,
  input wire logic i_erase_req,
  input wire logic i_erase_protected,
  // monitor serial pin
  input wire logic i_monitor_serial_pin,
  output logic o_monitor_serial_pin,
  output logic o_monitor_serial_pin_oe,
  // mode status
  output logic o_mode_valid,
  output logic o_monitor_mode,
  output logic o_hv_entry,
  output logic o_pll_enable,
  output logic o_array_blank,
  output logic o_ports_default,
  output logic [15:0] o_start_addr,
  // gates
  output logic o_rom_select,
  output logic o_prog_grant,
  output logic o_erase_grant,
  // host register writes
  output logic o_reg_wr,
  output logic [15:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);

  ////////////////////////////////////////////////////////////////////////
  // mode latch
  mme_pkg::mme_mode_t mode_q, mode_d;
  logic hv_q, hv_d, pll_q, pll_d, blank_q, blank_d;
  logic [15:0] start_q, start_d;
  logic vec_blank;

  assign vec_blank = (i_vec_hi_byte == mme_pkg::ERASED_BYTE) &&
                     (i_vec_lo_byte == mme_pkg::ERASED_BYTE);

  // decide once in the first cycle after reset, then freeze
  always_comb
  begin
    mode_d = mode_q;
    hv_d = hv_q;
    pll_d = pll_q;
    blank_d = blank_q;
    start_d = start_q;
    case (mode_q)
      mme_pkg::MME_LATCH:
      begin
        blank_d = vec_blank;
        if (i_test_entry_voltage)
        begin
          mode_d = mme_pkg::MME_MON;
          hv_d = 1'b1;
          pll_d = 1'b0;
          start_d = mme_pkg::MON_ROM_START;
        end
        else if (vec_blank)
        begin
          mode_d = mme_pkg::MME_MON;
          hv_d = 1'b0;
          pll_d = !i_irq_pin_level;
          start_d = mme_pkg::MON_ROM_START;
        end
        else
        begin
          mode_d = mme_pkg::MME_USER;
          hv_d = 1'b0;
          pll_d = 1'b0;
          start_d = {i_vec_hi_byte, i_vec_lo_byte};
        end
      end
      default:
      begin
        mode_d = mode_q;
      end
    endcase
  end

  // mode registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      mode_q <= mme_pkg::MME_LATCH;
      hv_q <= 1'b0;
      pll_q <= 1'b0;
      blank_q <= 1'b0;
      start_q <= mme_pkg::RST_ADDR;
    end
    else
    begin
      mode_q <= mode_d;
      hv_q <= hv_d;
      pll_q <= pll_d;
      blank_q <= blank_d;
      start_q <= start_d;
    end
  end

  logic mon;
  assign mon = (mode_q == mme_pkg::MME_MON);
  assign o_mode_valid = (mode_q != mme_pkg::MME_LATCH);
  assign o_monitor_mode = mon;
  assign o_hv_entry = hv_q;
  assign o_pll_enable = pll_q;
  assign o_array_blank = blank_q;
  assign o_start_addr = start_q;
  // nothing configures ports on blank part
  assign o_ports_default = blank_q || !o_mode_valid;

  ////////////////////////////////////////////////////////////////////////
  // rom select and flash gates
  // monitor routine window
  assign o_rom_select = mon && (i_cpu_addr >= mme_pkg::MON_ROM_START) &&
                        (i_cpu_addr <= mme_pkg::MON_ROM_END);
  assign o_prog_grant = i_prog_req && o_mode_valid && (mon || !blank_q);
  assign o_erase_grant = i_erase_req && o_mode_valid &&
                         (!i_erase_protected || (mon && hv_q));

  ////////////////////////////////////////////////////////////////////////
  // serial receiver, active only in monitor mode
  mme_pkg::mme_rx_t rx_q, rx_d;
  logic [11:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_done_q, rx_done_d;
  logic tx_busy;

  // start, eight data lsb first, stop
  always_comb
  begin
    rx_d = rx_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_done_d = 1'b0;
    if (rx_cnt_q != mme_pkg::CNT_ZERO)
    begin
      rx_cnt_d = rx_cnt_q - 12'h001;
    end
    case (rx_q)
      mme_pkg::MME_RX_IDLE:
      begin
        // half duplex: own echo must not be heard back
        if (mon && !tx_busy && !i_monitor_serial_pin)
        begin
          rx_d = mme_pkg::MME_RX_START;
          rx_cnt_d = mme_pkg::BAUD_HALF;
        end
      end
      mme_pkg::MME_RX_START:
      begin
        if (rx_cnt_q == mme_pkg::CNT_ZERO)
        begin
          // glitch shorter than half a bit is dropped
          rx_d = i_monitor_serial_pin ? mme_pkg::MME_RX_IDLE : mme_pkg::MME_RX_DATA;
          // count runs down to zero inclusive, so reload one short of a bit
          rx_cnt_d = mme_pkg::BAUD_DIV - 12'h001;
          rx_bit_d = 4'h0;
        end
      end
      mme_pkg::MME_RX_DATA:
      begin
        if (rx_cnt_q == mme_pkg::CNT_ZERO)
        begin
          rx_sh_d = {i_monitor_serial_pin, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 4'h1;
          rx_cnt_d = mme_pkg::BAUD_DIV - 12'h001;
          if (rx_bit_q == mme_pkg::DATA_BITS - 4'h1)
          begin
            rx_d = mme_pkg::MME_RX_STOP;
          end
        end
      end
      default:
      begin
        if (rx_cnt_q == mme_pkg::CNT_ZERO)
        begin
          // a bad stop bit discards the byte
          rx_done_d = i_monitor_serial_pin;
          rx_d = mme_pkg::MME_RX_IDLE;
        end
      end
    endcase
  end

  // receiver registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rx_q <= mme_pkg::MME_RX_IDLE;
      rx_cnt_q <= mme_pkg::CNT_ZERO;
      rx_bit_q <= 4'h0;
      rx_sh_q <= mme_pkg::RST_BYTE;
      rx_done_q <= 1'b0;
    end
    else
    begin
      rx_q <= rx_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_done_q <= rx_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // echo transmitter
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d;
  logic [11:0] tx_cnt_q, tx_cnt_d;

  assign tx_busy = (tx_left_q != 4'h0);

  // each bit held one 9600 baud time
  always_comb
  begin
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_cnt_d = tx_cnt_q;
    if (rx_done_q)
    begin
      tx_sh_d = {1'b1, rx_sh_q, 1'b0};
      tx_left_d = mme_pkg::TX_FRAME_BITS;
      tx_cnt_d = mme_pkg::BAUD_DIV;
    end
    else if (tx_busy)
    begin
      if (tx_cnt_q == 12'h001)
      begin
        tx_sh_d = {1'b1, tx_sh_q[9:1]};
        tx_left_d = tx_left_q - 4'h1;
        tx_cnt_d = mme_pkg::BAUD_DIV;
      end
      else
      begin
        tx_cnt_d = tx_cnt_q - 12'h001;
      end
    end
  end

  // transmitter registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tx_sh_q <= mme_pkg::RST_TX_SHIFT;
      tx_left_q <= 4'h0;
      tx_cnt_q <= mme_pkg::CNT_ZERO;
    end
    else
    begin
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  assign o_monitor_serial_pin = tx_sh_q[0];
  assign o_monitor_serial_pin_oe = tx_busy;

  ////////////////////////////////////////////////////////////////////////
  // host write sequencer: command, address high, address low, data
  logic [1:0] idx_q, idx_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wr_q, wr_d;

  always_comb
  begin
    idx_d = idx_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wr_d = 1'b0;
    if (rx_done_q)
    begin
      case (idx_q)
        mme_pkg::IDX_CMD:
        begin
          // unknown commands are ignored
          idx_d = (rx_sh_q == mme_pkg::CMD_WRITE) ? mme_pkg::IDX_AHI : mme_pkg::IDX_CMD;
        end
        mme_pkg::IDX_AHI:
        begin
          addr_d = {rx_sh_q, addr_q[7:0]};
          idx_d = mme_pkg::IDX_ALO;
        end
        mme_pkg::IDX_ALO:
        begin
          addr_d = {addr_q[15:8], rx_sh_q};
          idx_d = mme_pkg::IDX_DATA;
        end
        default:
        begin
          wdata_d = rx_sh_q;
          wr_d = 1'b1;
          idx_d = mme_pkg::IDX_CMD;
        end
      endcase
    end
  end

  // write registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      idx_q <= mme_pkg::IDX_CMD;
      addr_q <= mme_pkg::RST_ADDR;
      wdata_q <= mme_pkg::RST_BYTE;
      wr_q <= 1'b0;
    end
    else
    begin
      idx_q <= idx_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
    end
  end

  assign o_reg_wr = wr_q;
  assign o_reg_addr = addr_q;
  assign o_reg_wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_latch;
    (mode_q == mme_pkg::MME_LATCH);
  endsequence
  sequence s_last_byte;
    rx_done_q && (idx_q == mme_pkg::IDX_DATA);
  endsequence

  AST_ROM_WINDOW: assert property (o_rom_select |-> o_monitor_mode &&
    (i_cpu_addr >= 16'hfe20) && (i_cpu_addr <= 16'hff52))
    else $error("rom select outside monitor window");
  AST_PROG_BLANK: assert property (o_array_blank && !o_monitor_mode |-> !o_prog_grant)
    else $error("blank flash programmed outside monitor");
  AST_HOST_WRITE: assert property (s_last_byte |=> o_reg_wr &&
    (o_reg_wdata == $past(rx_sh_q)))
    else $error("host write not issued");
  AST_HV_ENTRY: assert property (s_latch ##0 i_test_entry_voltage |=>
    o_monitor_mode && o_hv_entry && !o_pll_enable)
    else $error("elevated level entry failed");
  AST_PLL_OFF_HV: assert property (o_hv_entry |-> !o_pll_enable)
    else $error("pll on in elevated entry");
  AST_BLANK_ENTRY: assert property (s_latch ##0 vec_blank |=> o_monitor_mode &&
    o_array_blank && (o_start_addr == 16'hfe20))
    else $error("blank vector entry failed");
  AST_PLL_BLANK: assert property (s_latch ##0 (!i_test_entry_voltage && vec_blank &&
    !i_irq_pin_level) |=> o_pll_enable)
    else $error("pll not on for blank entry");
  AST_ERASE_PROT: assert property (o_erase_grant && i_erase_protected |-> o_hv_entry)
    else $error("protected erase granted");
  AST_MODE_HOLD: assert property (o_mode_valid |=> $stable(o_monitor_mode) &&
    $stable(o_start_addr))
    else $error("mode changed after latch");
  AST_START_BIT: assert property ($rose(o_monitor_serial_pin_oe) |->
    (!o_monitor_serial_pin)[*8])
    else $error("start bit not held low");
  AST_MON_START: assert property (o_monitor_mode |-> o_start_addr == 16'hfe20)
    else $error("monitor start address wrong");
  AST_PORTS: assert property (o_array_blank |-> o_ports_default)
    else $error("ports left default state");

endmodule
`default_nettype wire

//--- verification/mme_host.sv
// host programmer model on the single monitor serial pin
`default_nettype none
module mme_host (
  // clock
  input wire logic i_clk,
  // device side of the pin
  input wire logic i_dev_pin,
  input wire logic i_dev_oe,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int XTAL_HZ = 9_830_400;
  logic tx_q = 1'b1;
  // released line floats to the pull-up level
  // isolated idle level
  assign o_line = i_dev_oe ? i_dev_pin : tx_q;
  // wait whole bit times
  task automatic bits(input int n);
    repeat (n * mme_pkg::BAUD_DIV) @(posedge i_clk);
  endtask
  // send one byte, then capture the echo frame and its length
  // 8n1 at 9600
  task automatic xfer(input logic [7:0] b, input logic bad, output logic [9:0] fr,
      output int len, output logic seen);
    fr = {1'b1, b, 1'b0};
    len = 0;
    seen = 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 9; i++)
    begin
      tx_q <= fr[i];
      bits(1);
    end
    // a zero stop bit is a framing fault the device must drop
    if (bad)
    begin
      tx_q <= 1'b0;
      bits(1);
    end
    tx_q <= 1'b1;
    fr = 'x;
    for (int k = 0; k < 2 * mme_pkg::BAUD_DIV && !seen; k++)
    begin
      @(negedge i_clk);
      seen = i_dev_oe;
    end
    // sample mid-bit while the device drives
    while (seen && i_dev_oe && len < 11 * mme_pkg::BAUD_DIV)
    begin
      if (len % mme_pkg::BAUD_DIV == mme_pkg::BAUD_HALF)
        fr[len / mme_pkg::BAUD_DIV] = o_line;
      len++;
      @(negedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the monitor mode entry block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_test_entry_voltage = 1'b0;
  logic i_irq_pin_level = 1'b0;
  logic [7:0] i_vec_hi_byte = 8'h00;
  logic [7:0] i_vec_lo_byte = 8'h00;
  logic [15:0] i_cpu_addr = 16'h0000;
  logic i_prog_req = 1'b0;
  logic i_erase_req = 1'b0;
  logic i_erase_protected = 1'b0;
  logic i_monitor_serial_pin;
  logic o_monitor_serial_pin, o_monitor_serial_pin_oe, o_mode_valid, o_monitor_mode;
  logic o_hv_entry, o_pll_enable, o_array_blank, o_ports_default, o_rom_select;
  logic o_prog_grant, o_erase_grant, o_reg_wr;
  logic [15:0] o_start_addr, o_reg_addr;
  logic [7:0] o_reg_wdata;
  int fail_count = 0;
  int n_tests = 0;
  int wr_cycles = 0;
  int len;
  logic seen;
  logic [9:0] fr;
  typedef struct packed {
    logic hv; logic irq; logic [15:0] vec;
    logic mon; logic hve; logic pll; logic blank; logic [15:0] start;
  } mme_row_t;
  // entry inputs beside the mode they must latch
  mme_row_t rows [6] = '{
    '{1'b1, 1'b1, 16'h1234, 1'b1, 1'b1, 1'b0, 1'b0, 16'hfe20},
    '{1'b0, 1'b0, 16'hffff, 1'b1, 1'b0, 1'b1, 1'b1, 16'hfe20},
    '{1'b0, 1'b1, 16'hffff, 1'b1, 1'b0, 1'b0, 1'b1, 16'hfe20},
    '{1'b0, 1'b0, 16'hfffe, 1'b0, 1'b0, 1'b0, 1'b0, 16'hfffe},
    '{1'b0, 1'b0, 16'h80ff, 1'b0, 1'b0, 1'b0, 1'b0, 16'h80ff},
    '{1'b1, 1'b0, 16'hffff, 1'b1, 1'b1, 1'b0, 1'b1, 16'hfe20}};
  logic [15:0] addrs [4] = '{16'hfe1f, 16'hfe20, 16'hff52, 16'hff53};
  logic [7:0] cmd [4] = '{8'h57, 8'h12, 8'h34, 8'ha5};
  always #20 i_clk = ~i_clk;
  mme_top u_mme_top (.i_clk, .i_srst, .i_test_entry_voltage, .i_irq_pin_level,
    .i_vec_hi_byte, .i_vec_lo_byte, .i_cpu_addr, .i_prog_req, .i_erase_req,
    .i_erase_protected, .i_monitor_serial_pin, .o_monitor_serial_pin,
    .o_monitor_serial_pin_oe, .o_mode_valid, .o_monitor_mode, .o_hv_entry, .o_pll_enable,
    .o_array_blank, .o_ports_default, .o_start_addr, .o_rom_select, .o_prog_grant,
    .o_erase_grant, .o_reg_wr, .o_reg_addr, .o_reg_wdata);
  mme_host u_mme_host (.i_clk, .i_dev_pin(o_monitor_serial_pin),
    .i_dev_oe(o_monitor_serial_pin_oe), .o_line(i_monitor_serial_pin));
  // width of the write strobe in cycles
  always @(posedge i_clk)
    if (o_reg_wr === 1'b1) wr_cycles++;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // power-on reset with entry levels, ends just after the latch edge
  task automatic boot(input logic hv, input logic irq, input logic [15:0] vec);
    i_srst <= 1'b1;
    i_test_entry_voltage <= hv;
    i_irq_pin_level <= irq;
    {i_vec_hi_byte, i_vec_lo_byte} <= vec;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    check({o_mode_valid, o_ports_default, o_monitor_serial_pin_oe, o_prog_grant}, 4'h4);
    @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
  endtask
  // watchdog well past the longest expected run
  initial
  begin
    #(400_000 * 40);
    fail_count++;
    conclude();
  end
  initial
  begin
    foreach (rows[r])
    begin
      boot(rows[r].hv, rows[r].irq, rows[r].vec);
      @(negedge i_clk);
      check({o_mode_valid, o_monitor_mode, o_hv_entry}, {1'b1, rows[r].mon, rows[r].hve});
      check(o_array_blank, rows[r].blank);
      check(o_pll_enable, rows[r].pll);
      check(o_start_addr, rows[r].start);
      check(o_ports_default, rows[r].blank);
      // later entry levels must not disturb the latched mode
      @(posedge i_clk);
      {i_test_entry_voltage, i_irq_pin_level} <= ~{rows[r].hv, rows[r].irq};
      {i_vec_hi_byte, i_vec_lo_byte} <= ~rows[r].vec;
      {i_prog_req, i_erase_req, i_erase_protected} <= 3'h7;
      foreach (addrs[a])
      begin
        i_cpu_addr <= addrs[a];
        @(negedge i_clk);
        check(o_rom_select, rows[r].mon && (a inside {1, 2}));
        @(posedge i_clk);
      end
      check({o_monitor_mode, o_pll_enable, o_hv_entry}, {rows[r].mon, rows[r].pll, rows[r].hve});
      check(o_start_addr, rows[r].start);
      check(o_prog_grant, rows[r].mon || !rows[r].blank);
      check(o_erase_grant, rows[r].mon && rows[r].hve);
      i_erase_protected <= 1'b0;
      @(negedge i_clk);
      check(o_erase_grant, 1'b1);
      @(posedge i_clk);
    end
    // monitor session: framing fault first, then a full register write
    boot(1'b1, 1'b0, 16'h1234);
    u_mme_host.xfer(8'h57, 1'b1, fr, len, seen);
    check(seen, 1'b0);
    foreach (cmd[i])
    begin
      u_mme_host.xfer(cmd[i], 1'b0, fr, len, seen);
      check(fr, {1'b1, cmd[i], 1'b0});
      check(16'(len), 16'(10 * mme_pkg::BAUD_DIV));
    end
    check(16'(wr_cycles), 16'h0001);
    check(o_reg_addr, 16'h1234);
    check(o_reg_wdata, 8'ha5);
    check(16'(u_mme_host.XTAL_HZ / 4 / mme_pkg::BAUD_HZ),
      16'(mme_pkg::BUS_CLK_PER_BIT));
    conclude();
  end
endmodule
`default_nettype wire
